//--- rtl/fifo_watermark_pointer_indirect.sv
// indirect access to rx watermark, tx start pointer and tx link pointer RAMs
//
// Design decision made here: strobed register access.
module fifo_watermark_pointer_indirect (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [fifo_ind_pkg::ADDR_W-1:0] ADDR,
    input wire logic [fifo_ind_pkg::DATA_W-1:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [fifo_ind_pkg::DATA_W-1:0] RDATA,
    input wire logic ENG_PTR_WE,
    input wire logic [fifo_ind_pkg::CHAN_W-1:0] ENG_PTR_CHAN,
    input wire logic [fifo_ind_pkg::VAL_W-1:0] ENG_PTR_VALUE,
    output logic RX_WM_INVALID
);
    import fifo_ind_pkg::*;

    typedef struct packed {
        unit_type [NUM_UNIT-1:0] unit;
        logic [DATA_W-1:0] rdata;
        logic wm_invalid;
    } top_state_type;

    top_state_type q, d;
    logic [NUM_UNIT-1:0] grant;
    logic [NUM_UNIT-1:0] is_wr;
    logic [NUM_UNIT-1:0] done_v;
    logic [NUM_UNIT-1:0][VAL_W-1:0] rdata_v;

    ram_port_if port_if[NUM_UNIT] ();

    ////////////////////////////////////////////////////////////////////////////
    // per-unit RAM and port steering

    always_comb begin
        for (int u = 0; u < NUM_UNIT; u++) begin
            is_wr[u] = (q.unit[u].dir == WR_ON_DIR1[u]); // [R2] [R3] [R8] [R13]
            // engine pointer updates take the start RAM first; the host access waits
            grant[u] = (q.unit[u].phase == PH_LAUNCH) && !((u == UNIT_SP) && ENG_PTR_WE);
        end
    end

    generate
        for (genvar g = 0; g < NUM_UNIT; g++) begin : g_unit
            if (g == UNIT_SP) begin : g_eng
                always_comb begin
                    if (ENG_PTR_WE) begin
                        // engine keeps moving the stored start pointer [R11]
                        port_if[g].req = 1'b1;
                        port_if[g].wr = 1'b1;
                        port_if[g].addr = {2'b00, ENG_PTR_CHAN};
                        port_if[g].wdata = ENG_PTR_VALUE;
                    end else begin
                        port_if[g].req = grant[g];
                        port_if[g].wr = is_wr[g];
                        port_if[g].addr = q.unit[g].idx;
                        port_if[g].wdata = q.unit[g].data;
                    end
                end
            end else begin : g_host
                always_comb begin
                    port_if[g].req = grant[g];
                    port_if[g].wr = is_wr[g];
                    port_if[g].addr = q.unit[g].idx;
                    port_if[g].wdata = q.unit[g].data;
                end
            end
            assign done_v[g] = port_if[g].done;
            assign rdata_v[g] = port_if[g].rdata;
            indirect_ram #(
                .DEPTH(unit_depth(g))
            ) u_ram (
                .clk(REF_CLK),
                .rst(SYS_RST),
                .port(port_if[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // register file and access sequencing

    always_comb begin
        d = q;
        d.rdata = RDATA_IDLE;
        d.wm_invalid = 1'b0;
        for (int u = 0; u < NUM_UNIT; u++) begin
            // data registers: plain binary 10-bit values [R5] [R9] [R12]
            if (WR_STB && (ADDR == DAT_OFFSETS[u])) begin
                d.unit[u].data = WDATA[VAL_W-1:0];
            end
            unique case (q.unit[u].phase)
                PH_IDLE: begin
                    // select writes while busy are dropped; software polls first
                    if (WR_STB && (ADDR == SEL_OFFSETS[u])) begin
                        d.unit[u].idx = WDATA[VAL_W-1:0] & IDX_MASKS[u]; // [R1] [R13]
                        d.unit[u].dir = WDATA[DIR_BIT];
                        d.unit[u].phase = PH_LAUNCH; // [R4]
                    end
                end
                PH_LAUNCH: begin
                    if (grant[u]) begin
                        d.unit[u].phase = PH_WAIT;
                    end
                end
                PH_WAIT: begin
                    if (done_v[u]) begin
                        if (!is_wr[u]) begin
                            // a read returns the live RAM value [R2] [R10] [R13]
                            d.unit[u].data = rdata_v[u];
                        end
                        d.unit[u].phase = PH_IDLE; // [R3] [R4] [R8]
                    end
                end
            endcase
            if (RD_STB && (ADDR == SEL_OFFSETS[u])) begin
                d.rdata = '0;
                d.rdata[BUSY_BIT] = (q.unit[u].phase != PH_IDLE); // [R4]
                d.rdata[DIR_BIT] = q.unit[u].dir;
                d.rdata[VAL_W-1:0] = q.unit[u].idx;
            end
            if (RD_STB && (ADDR == DAT_OFFSETS[u])) begin
                d.rdata = {{(DATA_W-VAL_W){1'b0}}, q.unit[u].data};
            end
        end
        // a zero watermark stored to RAM is flagged as invalid [R7]
        if (grant[UNIT_WM] && is_wr[UNIT_WM] && (q.unit[UNIT_WM].data == VAL_RESET)) begin
            d.wm_invalid = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign RDATA = q.rdata;
    assign RX_WM_INVALID = q.wm_invalid;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [NUM_UNIT-1:0] busy_v;
    always_comb begin
        for (int u = 0; u < NUM_UNIT; u++) begin
            busy_v[u] = (q.unit[u].phase != PH_IDLE);
        end
    end

    busy_sets_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R4]
        (WR_STB && ADDR == SEL_OFFSETS[UNIT_WM] && !busy_v[UNIT_WM]) |=> busy_v[UNIT_WM])
        else $error("busy not set after select write");

    busy_clears_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R4]
        $rose(busy_v[UNIT_LP]) |-> busy_v[UNIT_LP] ##1 busy_v[UNIT_LP] ##1 !busy_v[UNIT_LP])
        else $error("link busy not exactly two cycles");

    index_field_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R1]
        (WR_STB && ADDR == SEL_OFFSETS[UNIT_WM] && !busy_v[UNIT_WM])
        |=> q.unit[UNIT_WM].idx == {2'b00, $past(WDATA[CHAN_W-1:0])})
        else $error("channel index not captured");

    wm_fetch_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R2]
        (q.unit[UNIT_WM].phase == PH_WAIT && !is_wr[UNIT_WM])
        |=> (q.unit[UNIT_WM].data == $past(rdata_v[UNIT_WM])) && !busy_v[UNIT_WM])
        else $error("watermark not loaded when busy fell");

    wm_store_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R3]
        (WR_STB && ADDR == SEL_OFFSETS[UNIT_WM] && !busy_v[UNIT_WM] && !WDATA[DIR_BIT])
        |=> port_if[UNIT_WM].req && port_if[UNIT_WM].wr
            && port_if[UNIT_WM].wdata == q.unit[UNIT_WM].data)
        else $error("watermark write not issued");

    sp_store_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R8]
        (grant[UNIT_SP] && q.unit[UNIT_SP].dir)
        |-> port_if[UNIT_SP].wr ##1 port_if[UNIT_SP].done ##1 !busy_v[UNIT_SP])
        else $error("start pointer store not completed");

    eng_update_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R11]
        ENG_PTR_WE |-> port_if[UNIT_SP].req && port_if[UNIT_SP].wr
            && port_if[UNIT_SP].wdata == ENG_PTR_VALUE && !grant[UNIT_SP])
        else $error("engine pointer update lost");

    link_read_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R13]
        (grant[UNIT_LP] && q.unit[UNIT_LP].dir) |-> !port_if[UNIT_LP].wr
            && port_if[UNIT_LP].addr == q.unit[UNIT_LP].idx)
        else $error("link read issued as write");

    zero_flag_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R7]
        (grant[UNIT_WM] && is_wr[UNIT_WM] && q.unit[UNIT_WM].data == VAL_RESET)
        |=> RX_WM_INVALID)
        else $error("zero watermark not flagged");

    read_slot_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        !$past(RD_STB) |-> RDATA == RDATA_IDLE)
        else $error("read data outside its slot");

endmodule // fifo_watermark_pointer_indirect

//--- rtl/fifo_ind_pkg.sv
// constants and types for the indirect watermark and block pointer access block
// Summary of operation
// [R1] Bits 7:0 of each channel select register carry the channel index, 00h being channel 1 and FFh channel 256.
// [R2] Writing the receive watermark select with the direction bit 14 at 1 fetches that channel's watermark and keeps busy set until the data register holds it.
// [R3] Writing that direction bit at 0 copies the watermark data register into the channel's RAM entry and clears busy when done.
// [R4] Bit 15 of every select register is a read-only busy flag, high while an indirect read awaits data or a write is under way.
// [R5] A 10-bit receive high watermark is kept per channel, counting blocks written before the channel's data is moved out.
// [R6] Software must program each watermark between 1 and one less than the channel's chain length.
// [R7] The watermark is a plain binary block count, and zero is an invalid setting.
// [R8] Writing the transmit start pointer select with direction 1 stores the start pointer data register into the channel's RAM entry and clears busy when done.
// [R9] The transmit start pointer is a 10-bit value selecting one of 1024 blocks of the channel's chain.
// [R10] Reading the transmit start pointer returns the pointer the engines are currently using for that channel.
// [R11] Once written, the stored start pointer keeps being updated by the engine, so a later read may differ.
// [R12] The start pointer is a plain binary block number from 000h to 3FFh.
// [R13] The link pointer select reads the link RAM at the block index with direction 1 and writes the link data register there with direction 0.
// [R14] Software should poll busy until zero before reading data or starting another access on the same select register.
package fifo_ind_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int VAL_W = 10;
    localparam int CHAN_W = 8;
    localparam int NUM_UNIT = 3;
    localparam int CHAN_DEPTH = 256;
    localparam int BLOCK_DEPTH = 1024;

    // unit numbering
    localparam int UNIT_WM = 0;
    localparam int UNIT_SP = 1;
    localparam int UNIT_LP = 2;

    // register byte offsets, index by unit
    localparam logic [NUM_UNIT-1:0][ADDR_W-1:0] SEL_OFFSETS = {12'h990, 12'h980, 12'h920};
    localparam logic [NUM_UNIT-1:0][ADDR_W-1:0] DAT_OFFSETS = {12'h994, 12'h984, 12'h924};

    // field layout of select registers
    localparam int DIR_BIT = 14;
    localparam int BUSY_BIT = 15;
    localparam logic [NUM_UNIT-1:0][VAL_W-1:0] IDX_MASKS = {10'h3FF, 10'h0FF, 10'h0FF};

    // which units treat direction 1 as a RAM write
    localparam logic [NUM_UNIT-1:0] WR_ON_DIR1 = 3'b010;

    // reset values
    localparam logic [VAL_W-1:0] VAL_RESET = 10'h000;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_LAUNCH,
        PH_WAIT
    } phase_type;

    typedef struct packed {
        phase_type phase;
        logic dir;
        logic [VAL_W-1:0] idx;
        logic [VAL_W-1:0] data;
    } unit_type;

    function automatic int unit_depth(input int u);
        return (u == UNIT_LP) ? BLOCK_DEPTH : CHAN_DEPTH;
    endfunction

endpackage

//--- rtl/ram_port_if.sv
// request and answer signals between the access logic and one config RAM
interface ram_port_if;
    import fifo_ind_pkg::*;
    logic req;
    logic wr;
    logic [VAL_W-1:0] addr;
    logic [VAL_W-1:0] wdata;
    logic [VAL_W-1:0] rdata;
    logic done;
    modport ctrl (output req, output wr, output addr, output wdata, input rdata, input done);
    modport mem (input req, input wr, input addr, input wdata, output rdata, output done);
endinterface

//--- rtl/indirect_ram.sv
// single-port config RAM answering one request per cycle with a registered done
module indirect_ram #(
    parameter int DEPTH = 256
) (
    input wire logic clk,
    input wire logic rst,
    ram_port_if.mem port
);
    import fifo_ind_pkg::*;

    typedef struct packed {
        logic done;
        logic [VAL_W-1:0] rdata;
    } ram_state_type;

    // contents are not reset: software loads every entry before use
    logic [VAL_W-1:0] mem [DEPTH];
    ram_state_type q, d;

    always_comb begin
        d = q;
        d.done = port.req;
        if (port.req && !port.wr) begin
            d.rdata = mem[port.addr[$clog2(DEPTH)-1:0]];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge clk) begin
        if (port.req && port.wr) begin
            mem[port.addr[$clog2(DEPTH)-1:0]] <= port.wdata;
        end
    end

    assign port.done = q.done;
    assign port.rdata = q.rdata;

    ram_done_a: assert property (@(posedge clk) disable iff (rst)
        port.req |=> port.done)
        else $error("ram request not answered next cycle");

endmodule // indirect_ram

//--- verif/tb_top.sv
// self-checking bench for the indirect watermark and block pointer access block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fifo_ind_pkg::*;

    logic REF_CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [ADDR_W-1:0] ADDR = '0;
    logic [DATA_W-1:0] WDATA = '0;
    logic WR_STB = 1'b0;
    logic RD_STB = 1'b0;
    logic [DATA_W-1:0] RDATA;
    logic ENG_PTR_WE = 1'b0;
    logic [CHAN_W-1:0] ENG_PTR_CHAN = '0;
    logic [VAL_W-1:0] ENG_PTR_VALUE = '0;
    logic RX_WM_INVALID;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int inv_seen = 0;
    logic [DATA_W-1:0] got;

    fifo_watermark_pointer_indirect dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
        .ENG_PTR_WE(ENG_PTR_WE), .ENG_PTR_CHAN(ENG_PTR_CHAN), .ENG_PTR_VALUE(ENG_PTR_VALUE),
        .RX_WM_INVALID(RX_WM_INVALID));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 REF_CLK = ~REF_CLK;
    end

    // the ceiling is far above the hundred-odd cycles the tests need
    always @(posedge REF_CLK) begin
        cycles = cycles + 1;
        if (RX_WM_INVALID === 1'b1) inv_seen = inv_seen + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] act);
        checks_done = checks_done + 1;
        if (act !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD %s expected %h seen %h", what, exp, act);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        @(posedge REF_CLK);
        WR_STB <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge REF_CLK);
        RD_STB <= 1'b0;
        #1 d = RDATA;
    endtask

    task automatic poll(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        int i;
        for (i = 0; i < 20; i++) begin
            rd(a, d);
            if (d[BUSY_BIT] === 1'b0) break;
        end
        if (i == 20) chk("busy timeout", 16'h0000, d);
    endtask

    function automatic logic [DATA_W-1:0] sel_word(input logic dir, input logic [VAL_W-1:0] idx);
        logic [DATA_W-1:0] v;
        v = 16'h0000;
        v[DIR_BIT] = dir;
        v[VAL_W-1:0] = idx;
        return v;
    endfunction

    task automatic ind(input int u, input logic dir, input logic [VAL_W-1:0] idx);
        wr(SEL_OFFSETS[u], sel_word(dir, idx));
        poll(SEL_OFFSETS[u], got);
        chk("select", sel_word(dir, idx), got);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        for (int u = 0; u < NUM_UNIT; u++) begin
            rd(SEL_OFFSETS[u], got);
            chk("select reset", 16'h0000, got);
            rd(DAT_OFFSETS[u], got);
            chk("data reset", 16'h0000, got);
        end
        rd(12'hFFC, got);
        chk("unmapped", 16'h0000, got);
        $display("test reset done");

        // watermark legal values only, except the deliberate zero below
        wr(DAT_OFFSETS[UNIT_WM], 16'h03FF);
        ind(UNIT_WM, 1'b0, 10'h0FF);
        wr(DAT_OFFSETS[UNIT_WM], 16'h0001);
        ind(UNIT_WM, 1'b0, 10'h000);
        wr(DAT_OFFSETS[UNIT_WM], 16'h0000);
        // second select write lands while busy and must be dropped
        wr(SEL_OFFSETS[UNIT_WM], sel_word(1'b1, 10'h0FF));
        wr(SEL_OFFSETS[UNIT_WM], sel_word(1'b1, 10'h000));
        poll(SEL_OFFSETS[UNIT_WM], got);
        chk("select kept", sel_word(1'b1, 10'h0FF), got);
        rd(DAT_OFFSETS[UNIT_WM], got);
        chk("watermark 256", 16'h03FF, got);
        ind(UNIT_WM, 1'b1, 10'h000);
        rd(DAT_OFFSETS[UNIT_WM], got);
        chk("watermark 1", 16'h0001, got);
        chk("no invalid", 16'h0000, 16'(inv_seen));
        wr(DAT_OFFSETS[UNIT_WM], 16'h0000);
        ind(UNIT_WM, 1'b0, 10'h005);
        chk("invalid pulse", 16'h0001, 16'(inv_seen));
        $display("test watermark done");

        wr(DAT_OFFSETS[UNIT_SP], 16'h01FF);
        ind(UNIT_SP, 1'b1, 10'h005);
        wr(DAT_OFFSETS[UNIT_SP], 16'h0000);
        ind(UNIT_SP, 1'b0, 10'h005);
        rd(DAT_OFFSETS[UNIT_SP], got);
        chk("start ptr", 16'h01FF, got);
        @(posedge REF_CLK);
        ENG_PTR_WE <= 1'b1;
        ENG_PTR_CHAN <= 8'h05;
        ENG_PTR_VALUE <= 10'h3FF;
        @(posedge REF_CLK);
        ENG_PTR_WE <= 1'b0;
        ind(UNIT_SP, 1'b0, 10'h005);
        rd(DAT_OFFSETS[UNIT_SP], got);
        chk("engine ptr", 16'h03FF, got);
        // engine pulse lands in the host issue cycle: host read must wait and see the new value
        wr(SEL_OFFSETS[UNIT_SP], sel_word(1'b0, 10'h005));
        ENG_PTR_WE <= 1'b1;
        ENG_PTR_VALUE <= 10'h123;
        @(posedge REF_CLK);
        ENG_PTR_WE <= 1'b0;
        poll(SEL_OFFSETS[UNIT_SP], got);
        rd(DAT_OFFSETS[UNIT_SP], got);
        chk("engine first", 16'h0123, got);
        $display("test start pointer done");

        wr(DAT_OFFSETS[UNIT_LP], 16'hFFFF);
        rd(DAT_OFFSETS[UNIT_LP], got);
        chk("link unused bits", 16'h03FF, got);
        wr(DAT_OFFSETS[UNIT_LP], 16'h02AA);
        ind(UNIT_LP, 1'b0, 10'h3FF);
        wr(DAT_OFFSETS[UNIT_LP], 16'h0000);
        wr(SEL_OFFSETS[UNIT_LP], sel_word(1'b1, 10'h3FF));
        rd(SEL_OFFSETS[UNIT_LP], got);
        chk("busy bit", 16'h0001, {15'h0000, got[BUSY_BIT]});
        poll(SEL_OFFSETS[UNIT_LP], got);
        rd(DAT_OFFSETS[UNIT_LP], got);
        chk("link ptr", 16'h02AA, got);
        $display("test link pointer done");
        print_verdict();
    end
endmodule // tb_top
